// ==== shared/cie_cfg.svh ====
// Constants for the clear instruction executor.
// Assumes inclusion by bare name from design and bench files.
`ifndef CIE_CFG_SVH
`define CIE_CFG_SVH
// Opcode patterns, upper seven bits of the 14-bit word
`define CIE_REGZ_PAT   7'h03
`define CIE_ACCZ_PAT   7'h02
// Complete watchdog restart word
`define CIE_WDTR_WORD  14'h0064
// Field positions inside an instruction word
`define CIE_OPC_HI     13
`define CIE_OPC_LO     7
`define CIE_IDX_HI     6
`define CIE_IDX_LO     0
// Value written by every clearing operation
`define CIE_ZERO_BYTE  8'h00
// Bus register byte offsets
`define CIE_ADR_CTRL   8'h00
`define CIE_ADR_STAT   8'h04
`define CIE_ADR_COUNT  8'h08
// Reset values and field positions of bus registers
`define CIE_CTRL_RST   1'h1
`define CIE_CTRL_EN    0
`define CIE_COUNT_RST  16'h0000
`define CIE_COUNT_ONE  16'h0001
`define CIE_RDATA_ZERO 32'h00000000
`endif

// ==== shared/cie_pkg.sv ====
// Types used by the clear instruction executor, not by its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package cie_pkg;
  // Phase of the instruction cycle, one system clock each
  typedef enum logic [1:0] {
    CIE_Q1 = 2'b00,
    CIE_Q2 = 2'b01,
    CIE_Q3 = 2'b10,
    CIE_Q4 = 2'b11
  } cie_phase_e;
  // Operation latched at the end of the decode phase
  typedef enum logic [1:0] {
    CIE_OP_NONE = 2'b00,
    CIE_OP_REGZ = 2'b01,
    CIE_OP_ACCZ = 2'b10,
    CIE_OP_WDTR = 2'b11
  } cie_op_e;
endpackage : cie_pkg

// ==== src/cie_clear_executor.sv ====
// Executes the three clearing instructions of an 8-bit core.
// Assumes fetch logic on i_clk_sys presents a word during Q1 and
// that register file, status and watchdog act on the strobes.
//
// Overview of operation
// - Upper seven bits 0000011 mean register zeroing; low seven select.
// - Register zeroing writes zero to the selected register, sets null.
// - Register zeroing takes one word and one cycle, never stalls.
// - Phases: decode, read register, process, write zero back.
// - Watchdog restart word clears the watchdog count in the fourth phase.
// - Watchdog restart also clears the watchdog prescaler count.
// - Watchdog restart sets both watchdog and sleep status flags only.
//
// The Wishbone register port and the register addresses were decided locally.
`include "cie_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module cie_clear_executor (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  // Instruction word from fetch, same clock
  input  wire logic [13:0] i_instr_word,
  input  wire logic        i_instr_valid,
  input  wire logic [7:0]  i_rf_rdata,
  // Classic Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Phase and register file
  output logic      [1:0]  o_phase,
  output logic      [6:0]  o_rf_addr,
  output logic             o_rf_rd,
  output logic             o_rf_wr,
  output logic      [7:0]  o_rf_wdata,
  // Accumulator
  output logic             o_acc_wr,
  output logic      [7:0]  o_acc_wdata,
  // Status and watchdog strobes
  output logic             o_result_null_flag_set,
  output logic             o_watchdog_expired_n_flag_set,
  output logic             o_sleep_entered_n_flag_set,
  output logic             o_watchdog_count_clr,
  output logic             o_watchdog_prescale_clr
);

  // Instruction decoder, used for the live word
  function automatic cie_pkg::cie_op_e decode_op(
    input logic [13:0] word,
    input logic        en
  );
    logic [6:0] opc;
    opc = word[`CIE_OPC_HI:`CIE_OPC_LO];
    if (!en) begin
      decode_op = cie_pkg::CIE_OP_NONE;
    end else if (opc == `CIE_REGZ_PAT) begin
      decode_op = cie_pkg::CIE_OP_REGZ;
    end else if (opc == `CIE_ACCZ_PAT) begin
      decode_op = cie_pkg::CIE_OP_ACCZ;
    end else if (word == `CIE_WDTR_WORD) begin
      decode_op = cie_pkg::CIE_OP_WDTR;
    end else begin
      decode_op = cie_pkg::CIE_OP_NONE;
    end
  endfunction

  // Sequencer state
  cie_pkg::cie_phase_e phase;
  cie_pkg::cie_phase_e next_phase;
  cie_pkg::cie_op_e    op;
  cie_pkg::cie_op_e    next_op;
  logic [6:0]          idx;
  logic [6:0]          next_idx;
  logic [7:0]          rd_val;
  logic [7:0]          next_rd_val;
  logic [7:0]          res;
  logic [7:0]          next_res;
  logic                done;
  logic                next_done;

  // Registered outputs of the sequencer
  logic [6:0] next_rf_addr;
  logic       next_rf_rd;
  logic       next_rf_wr;
  logic       next_acc_wr;
  logic       next_null_set;
  logic       next_wdt_clr;
  logic       next_psc_clr;
  logic       next_to_set;
  logic       next_pd_set;

  // Bus registers
  logic        ctrl_en;
  logic        next_ctrl_en;
  logic [15:0] count;
  logic [15:0] next_count;
  logic        next_ack;
  logic [31:0] next_wb_dat;
  logic        bus_req;
  logic        bus_wr;

  // A new request only when not already acknowledging
  assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign bus_wr  = bus_req && i_wb_we;

  // Next values of the four-phase sequencer
  always_comb begin
    next_phase    = phase;
    next_op       = op;
    next_idx      = idx;
    next_rd_val   = rd_val;
    next_res      = res;
    next_done     = 1'b0;
    next_rf_addr  = o_rf_addr;
    next_rf_rd    = 1'b0;
    next_rf_wr    = 1'b0;
    next_acc_wr   = 1'b0;
    next_null_set = 1'b0;
    next_wdt_clr  = 1'b0;
    next_psc_clr  = 1'b0;
    next_to_set   = 1'b0;
    next_pd_set   = 1'b0;
    case (phase)
      cie_pkg::CIE_Q1: begin
        // Decode; a missing word leaves the cycle idle
        next_phase = cie_pkg::CIE_Q2;
        next_op    = i_instr_valid ?
                     decode_op(i_instr_word, ctrl_en) :
                     cie_pkg::CIE_OP_NONE;
        if (next_op == cie_pkg::CIE_OP_REGZ) begin
          next_idx     = i_instr_word[`CIE_IDX_HI:`CIE_IDX_LO];
          next_rf_addr = next_idx;
          next_rf_rd   = 1'b1;
        end
      end
      cie_pkg::CIE_Q2: begin
        // Read phase; only register zeroing samples the file
        next_phase = cie_pkg::CIE_Q3;
        if (op == cie_pkg::CIE_OP_REGZ) begin
          next_rd_val = i_rf_rdata;
        end
      end
      cie_pkg::CIE_Q3: begin
        // Process: result of every clear is zero
        next_phase = cie_pkg::CIE_Q4;
        next_res   = `CIE_ZERO_BYTE;
        case (op)
          cie_pkg::CIE_OP_REGZ: begin
            next_rf_wr    = 1'b1;
            next_null_set = 1'b1;
            next_done     = 1'b1;
          end
          cie_pkg::CIE_OP_ACCZ: begin
            next_acc_wr   = 1'b1;
            next_null_set = 1'b1;
            next_done     = 1'b1;
          end
          cie_pkg::CIE_OP_WDTR: begin
            next_wdt_clr = 1'b1;
            next_psc_clr = 1'b1;
            next_to_set  = 1'b1;
            next_pd_set  = 1'b1;
            next_done    = 1'b1;
          end
          default: begin
            next_done = 1'b0;
          end
        endcase
      end
      cie_pkg::CIE_Q4: begin
        // Back to decode with no extra cycle
        next_phase = cie_pkg::CIE_Q1;
      end
      default: begin
        next_phase = cie_pkg::CIE_Q1;
      end
    endcase
  end

  // Sequencer registers; strobes are high for exactly one phase
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      phase                         <= cie_pkg::CIE_Q1;
      op                            <= cie_pkg::CIE_OP_NONE;
      idx                           <= 7'h00;
      rd_val                        <= 8'h00;
      res                           <= `CIE_ZERO_BYTE;
      done                          <= 1'b0;
      o_phase                       <= 2'h0;
      o_rf_addr                     <= 7'h00;
      o_rf_rd                       <= 1'b0;
      o_rf_wr                       <= 1'b0;
      o_rf_wdata                    <= `CIE_ZERO_BYTE;
      o_acc_wr                      <= 1'b0;
      o_acc_wdata                   <= `CIE_ZERO_BYTE;
      o_result_null_flag_set        <= 1'b0;
      o_watchdog_count_clr          <= 1'b0;
      o_watchdog_prescale_clr       <= 1'b0;
      o_watchdog_expired_n_flag_set <= 1'b0;
      o_sleep_entered_n_flag_set    <= 1'b0;
    end else begin
      phase                         <= next_phase;
      op                            <= next_op;
      idx                           <= next_idx;
      rd_val                        <= next_rd_val;
      res                           <= next_res;
      done                          <= next_done;
      o_phase                       <= next_phase;
      o_rf_addr                     <= next_rf_addr;
      o_rf_rd                       <= next_rf_rd;
      o_rf_wr                       <= next_rf_wr;
      o_rf_wdata                    <= next_res;
      o_acc_wr                      <= next_acc_wr;
      o_acc_wdata                   <= next_res;
      o_result_null_flag_set        <= next_null_set;
      o_watchdog_count_clr          <= next_wdt_clr;
      o_watchdog_prescale_clr       <= next_psc_clr;
      o_watchdog_expired_n_flag_set <= next_to_set;
      o_sleep_entered_n_flag_set    <= next_pd_set;
    end
  end

  // Next values of the bus slave and its registers
  always_comb begin
    next_ctrl_en = ctrl_en;
    next_count   = count;
    next_ack     = bus_req;
    next_wb_dat  = `CIE_RDATA_ZERO;
    if (bus_wr && i_wb_sel[0] &&
        (i_wb_adr == `CIE_ADR_CTRL)) begin
      next_ctrl_en = i_wb_dat[`CIE_CTRL_EN];
    end
    // A write clears the counter, but a finishing op still counts
    if (bus_wr && (i_wb_adr == `CIE_ADR_COUNT) &&
        (i_wb_sel[1:0] != 2'h0)) begin
      next_count = done ? `CIE_COUNT_ONE : `CIE_COUNT_RST;
    end else if (done) begin
      next_count = count + `CIE_COUNT_ONE;
    end
    if (bus_req && !i_wb_we) begin
      case (i_wb_adr)
        `CIE_ADR_CTRL: begin
          next_wb_dat = {31'h00000000, ctrl_en};
        end
        `CIE_ADR_STAT: begin
          // Last op, operand index and value seen before clearing
          next_wb_dat = {15'h0000, rd_val, idx, op};
        end
        `CIE_ADR_COUNT: begin
          next_wb_dat = {16'h0000, count};
        end
        default: begin
          next_wb_dat = `CIE_RDATA_ZERO;
        end
      endcase
    end
  end

  // Bus registers; ack follows the request by one clock
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ctrl_en  <= `CIE_CTRL_RST;
      count    <= `CIE_COUNT_RST;
      o_wb_ack <= 1'b0;
      o_wb_dat <= `CIE_RDATA_ZERO;
    end else begin
      ctrl_en  <= next_ctrl_en;
      count    <= next_count;
      o_wb_ack <= next_ack;
      o_wb_dat <= next_wb_dat;
    end
  end

endmodule // cie_clear_executor

`default_nettype wire

// ==== dv/cie_clear_sva.sv ====
// Port checker for the clear instruction executor.
// Assumes a bind onto cie_clear_executor, one clock domain.
`include "cie_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cie_clear_sva (
  input wire logic        i_clk_sys,
  input wire logic        i_srst,
  input wire logic [13:0] i_instr_word,
  input wire logic        i_instr_valid,
  input wire logic [1:0]  o_phase,
  input wire logic [6:0]  o_rf_addr,
  input wire logic        o_rf_rd,
  input wire logic        o_rf_wr,
  input wire logic [7:0]  o_rf_wdata,
  input wire logic        o_acc_wr,
  input wire logic [7:0]  o_acc_wdata,
  input wire logic        o_result_null_flag_set,
  input wire logic        o_watchdog_expired_n_flag_set,
  input wire logic        o_sleep_entered_n_flag_set,
  input wire logic        o_watchdog_count_clr,
  input wire logic        o_watchdog_prescale_clr
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // Decode-edge views; enable is internal, so checks look backwards
  wire logic [6:0] opc = i_instr_word[13:7];
  wire logic [6:0] idx = i_instr_word[6:0];
  wire logic q1v = o_phase == 2'h0 && i_instr_valid;
  wire logic q1_regz = q1v && opc == `CIE_REGZ_PAT;
  wire logic q1_accz = q1v && opc == `CIE_ACCZ_PAT;
  wire logic q1_wdtr = q1v && i_instr_word == `CIE_WDTR_WORD;
  wire logic [3:0] wd = {o_watchdog_count_clr, o_watchdog_prescale_clr,
    o_watchdog_expired_n_flag_set, o_sleep_entered_n_flag_set};
  // Read in Q2, idle Q3, zero write in Q4
  sequence s_regz_tail;
    ##1 !o_rf_wr ##1 (o_rf_wr && o_rf_wdata == `CIE_ZERO_BYTE
      && o_result_null_flag_set && o_phase == 2'h3);
  endsequence
  // First edge after release still sees the reset phase as its past
  a_phase_step: assert property (!$past(i_srst) |->
    o_phase == $past(o_phase) + 2'h1)
    else $error("phase did not advance by one");
  a_regz_read: assert property (o_rf_rd |-> $past(q1_regz) &&
    o_rf_addr == $past(idx)) else $error("bad register read strobe");
  a_regz_write: assert property (o_rf_rd |-> s_regz_tail)
    else $error("register zero write missing");
  a_regz_cause: assert property (o_rf_wr |-> $past(o_rf_rd, 2))
    else $error("register write without read");
  a_acc_zero: assert property (o_acc_wr |-> $past(q1_accz, 3) &&
    o_acc_wdata == `CIE_ZERO_BYTE && o_result_null_flag_set && !o_rf_wr)
    else $error("bad accumulator clear");
  a_acc_noread: assert property (q1_accz |=> !o_rf_rd ##2 !o_rf_wr)
    else $error("accumulator clear touched registers");
  a_wdt_cause: assert property (o_watchdog_count_clr |->
    o_phase == 2'h3 && $past(q1_wdtr, 3)) else $error("bad wdt clear");
  a_wdt_group: assert property (|wd |-> &wd &&
    !o_result_null_flag_set) else $error("wdt strobes split");
  a_null_cause: assert property (o_result_null_flag_set |->
    o_rf_wr || o_acc_wr) else $error("null flag without clear");
endmodule // cie_clear_sva
bind cie_clear_executor cie_clear_sva cie_clear_sva_i (.*);
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the clear instruction executor.
// Assumes the design and the checker bind are compiled before it.
`include "cie_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_clk_sys, i_srst, i_instr_valid, i_wb_cyc, i_wb_stb;
  logic        i_wb_we, o_wb_ack, o_rf_rd, o_rf_wr, o_acc_wr;
  logic        o_result_null_flag_set, o_watchdog_expired_n_flag_set;
  logic        o_sleep_entered_n_flag_set, o_watchdog_count_clr;
  logic        o_watchdog_prescale_clr;
  logic [13:0] i_instr_word;
  logic [7:0]  i_rf_rdata, i_wb_adr, o_rf_wdata, o_acc_wdata;
  logic [6:0]  o_rf_addr;
  logic [3:0]  i_wb_sel;
  logic [1:0]  o_phase;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  int          mismatches, check_count;
  wire logic [7:0] stb = {o_rf_rd, o_rf_wr, o_acc_wr,
    o_result_null_flag_set, o_watchdog_expired_n_flag_set,
    o_sleep_entered_n_flag_set, o_watchdog_count_clr,
    o_watchdog_prescale_clr};
  cie_clear_executor cie_clear_executor_i (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Classic single cycle; ends on a falling edge to avoid races
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do @(posedge i_clk_sys); while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(negedge i_clk_sys);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // One word in Q1, strobes checked in Q2, Q3 and Q4
  task automatic op(input logic [13:0] w, input logic [7:0] e2, e4);
    while (o_phase !== 2'h3) @(negedge i_clk_sys);
    @(posedge i_clk_sys);
    i_instr_word  <= w;
    i_instr_valid <= 1'b1;
    i_rf_rdata    <= w[7:0] + 8'h11;
    @(posedge i_clk_sys);
    i_instr_valid <= 1'b0;
    i_instr_word  <= ~w; // Stale word must not decode
    @(negedge i_clk_sys);
    chk(stb, e2);
    @(negedge i_clk_sys);
    chk(stb, 8'h00);
    @(negedge i_clk_sys);
    chk(stb, e4);
    chk({o_rf_wdata, o_acc_wdata}, 32'h0);
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  // Hang guard, far beyond the roughly 120 cycles needed
  initial begin
    repeat (4000) @(posedge i_clk_sys);
    mismatches++;
    end_sim();
  end
  initial begin
    {i_srst, i_wb_sel} = 5'h1F;
    {i_instr_valid, i_wb_cyc, i_wb_stb, i_wb_we} = 4'h0;
    {i_instr_word, i_rf_rdata, i_wb_adr, i_wb_dat} = 62'h0;
    repeat (20) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    @(negedge i_clk_sys);
    // Reset values and an unmapped hole
    rdc(`CIE_ADR_CTRL, 32'h1);
    rdc(`CIE_ADR_STAT, 32'h0);
    rdc(`CIE_ADR_COUNT, 32'h0);
    rdc(8'h0C, 32'h0);
    // Top index, then back to back with index zero
    op(14'h01FF, 8'h80, 8'h50);
    chk(o_rf_addr, 32'h7F);
    op(14'h0180, 8'h80, 8'h50);
    chk(o_rf_addr, 32'h0);
    rdc(`CIE_ADR_STAT, 32'h12201);
    wb(1'b1, `CIE_ADR_STAT, 32'hFFFFFFFF);
    // An idle cycle has since decoded, so the op field now reads none
    rdc(`CIE_ADR_STAT, 32'h12200);
    // Accumulator clears with low bits set and clear, then restart
    op(14'h017F, 8'h00, 8'h30);
    op(14'h0100, 8'h00, 8'h30);
    op(14'h0064, 8'h00, 8'h0F);
    rdc(`CIE_ADR_COUNT, 32'h5);
    wb(1'b1, `CIE_ADR_COUNT, 32'h0);
    rdc(`CIE_ADR_COUNT, 32'h0);
    // Near misses of the restart word and the accumulator pattern do nothing
    op(14'h0065, 8'h00, 8'h00);
    op(14'h2064, 8'h00, 8'h00);
    op(14'h0264, 8'h00, 8'h00);
    op(14'h0000, 8'h00, 8'h00);
    // Disabled core ignores every word
    wb(1'b1, `CIE_ADR_CTRL, 32'h0);
    rdc(`CIE_ADR_CTRL, 32'h0);
    op(14'h0064, 8'h00, 8'h00);
    op(14'h01AA, 8'h00, 8'h00);
    wb(1'b1, `CIE_ADR_CTRL, 32'h1);
    op(14'h01AA, 8'h80, 8'h50);
    end_sim();
  end
endmodule // tb
`default_nettype wire
